/* File: verilog/ccs_pkg.sv */
package ccs_pkg;

  // Register offsets
  localparam logic [7:0] ERR_CTL_ADDR = 8'h46;
  localparam logic [7:0] ERR_FLAGS_ADDR = 8'h47;
  localparam logic [7:0] LINK_CAP_ADDR = 8'h4A;
  localparam logic [7:0] PORT_SELECT_ADDR = 8'h4C;

  // Field positions in control_channel_error_flags
  localparam int SEQ_ERR_BIT = 5;
  localparam int CTRL_ERR_BIT = 4;
  localparam int CTRL_TO_BIT = 3;
  localparam int TGT_ERR_BIT = 2;
  localparam int TGT_TO_BIT = 1;
  localparam int RESP_ERR_BIT = 0;
  localparam int FLAG_W = 6;

  // Field positions in link_capability and error control
  localparam int ENC_CRC_CAP_BIT = 4;
  localparam int ENH_EN_BIT = 5;

  // Values after reset
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam logic ENC_CRC_CAP_RST = 1'b0;
  localparam logic ENH_EN_RST = 1'b1;

endpackage : ccs_pkg

/* File: verilog/port_error_flags.sv */
`timescale 1ns/1ns
module port_error_flags
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Configuration
  input wire logic enh_en_i,
  input wire logic crc_cap_i,
  // Link events
  input wire logic seq_err_i,
  input wire logic crc_err_i,
  input wire logic lock_err_i,
  input wire logic enc_crc_err_i,
  input wire logic wdt_expire_i,
  input wire logic ctrl_wait_i,
  input wire logic tgt_wait_i,
  input wire logic resp_mismatch_i,
  input wire logic port_seq_err_i,
  // Read side effect
  input wire logic clear_i,
  // Status
  output logic [5:0] flags_o,
  output logic abort_o
);

  logic [5:0] flags_reg;
  logic [5:0] flags_next;
  logic abort_reg;
  logic abort_next;
  logic [5:0] set_vec;
  logic fwd_err;

  always_comb
  begin
    // Encoder CRC only counts when the capability bit allows it
    fwd_err = enh_en_i & (seq_err_i | crc_err_i | lock_err_i |
      (enc_crc_err_i & crc_cap_i));
    set_vec = '0;
    set_vec[ccs_pkg::SEQ_ERR_BIT] = seq_err_i;
    set_vec[ccs_pkg::CTRL_ERR_BIT] = fwd_err & ctrl_wait_i;
    set_vec[ccs_pkg::CTRL_TO_BIT] =
      enh_en_i & wdt_expire_i & ctrl_wait_i;
    set_vec[ccs_pkg::TGT_ERR_BIT] = fwd_err & tgt_wait_i;
    set_vec[ccs_pkg::TGT_TO_BIT] = wdt_expire_i & tgt_wait_i;
    set_vec[ccs_pkg::RESP_ERR_BIT] =
      enh_en_i & tgt_wait_i & resp_mismatch_i;
    // Set wins over the read clear
    flags_next = (clear_i ? 6'h00 : flags_reg) | set_vec;
    if (!enh_en_i)
    begin
      flags_next[ccs_pkg::SEQ_ERR_BIT] = port_seq_err_i;
    end
    else if (clear_i)
    begin
      flags_next[ccs_pkg::SEQ_ERR_BIT] = seq_err_i;
    end
    abort_next = fwd_err & (ctrl_wait_i | tgt_wait_i);
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      flags_reg <= ccs_pkg::FLAGS_RST;
      abort_reg <= 1'b0;
    end
    else
    begin
      flags_reg <= flags_next;
      abort_reg <= abort_next;
    end
  end

  assign flags_o = flags_reg;
  assign abort_o = abort_reg;

  property p_seq_mirror;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    !enh_en_i |=> flags_o[5] == $past(port_seq_err_i);
  endproperty
  a_seq_mirror: assert property (p_seq_mirror)
    else $error("sequence flag does not mirror port status");

  property p_seq_set;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    enh_en_i && seq_err_i |=> flags_o[5];
  endproperty
  a_seq_set: assert property (p_seq_set)
    else $error("sequence error not recorded");

  property p_seq_clear;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    enh_en_i && clear_i && !seq_err_i |=> !flags_o[5];
  endproperty
  a_seq_clear: assert property (p_seq_clear)
    else $error("sequence flag not cleared by read");

  property p_ctrl_err;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    enh_en_i && ctrl_wait_i && (seq_err_i || lock_err_i)
      |=> flags_o[4];
  endproperty
  a_ctrl_err: assert property (p_ctrl_err)
    else $error("controller error flag missing");

  property p_ctrl_to;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    enh_en_i && ctrl_wait_i && wdt_expire_i |=> flags_o[3];
  endproperty
  a_ctrl_to: assert property (p_ctrl_to)
    else $error("controller timeout flag missing");

  property p_tgt_err;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    enh_en_i && tgt_wait_i && crc_err_i |=> flags_o[2] && abort_o;
  endproperty
  a_tgt_err: assert property (p_tgt_err)
    else $error("target error flag or abort missing");

  property p_tgt_to;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    tgt_wait_i && wdt_expire_i |=> flags_o[1];
  endproperty
  a_tgt_to: assert property (p_tgt_to)
    else $error("target timeout flag missing");

  property p_resp;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    clear_i && !(enh_en_i && tgt_wait_i && resp_mismatch_i) |=> !flags_o[0];
  endproperty
  a_resp: assert property (p_resp)
    else $error("response flag not cleared or set wrongly");

  property p_gate;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    !enh_en_i && flags_o[4:2] == 3'b000 && !flags_o[0]
      |=> flags_o[4:2] == 3'b000 && !flags_o[0];
  endproperty
  a_gate: assert property (p_gate)
    else $error("flag raised with enhanced checking off");

  property p_crc_cap;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    !crc_cap_i && enc_crc_err_i && !seq_err_i && !crc_err_i && !lock_err_i
      |=> !abort_o;
  endproperty
  a_crc_cap: assert property (p_crc_cap)
    else $error("encoder crc error not suppressed");

endmodule : port_error_flags

/* File: verilog/control_channel_error_status.sv */
`timescale 1ns/1ns
// Operation
// - Sequence error on forward control channel sets status bit 5.
// - Enhanced checking off: bit 5 mirrors the port status sequence bit.
// - Enhanced checking on: bit 5 is held here and cleared by read.
// - Forward error while controller side waits sets bit 4, read clears.
// - Watchdog expiry while controller side waits sets bit 3, read clears.
// - Forward error while target side waits sets bit 2, read clears.
// - Watchdog expiry while target side waits sets bit 1, read clears.
// - Serializer echoes target data; mismatch sets response bit 0.
// - Bits 4, 3, 2 and 0 report only with enhanced checking on.
// - Capability bit 4 gates the encoder CRC error flag.
// - Each receive port has its own copy, chosen by port select.
// - Enhanced checking enable resets to 1; off stops abort and detection for bits 4, 3, 2 and 0.
module control_channel_error_status
#(
  parameter int NUM_PORTS = 4
)
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Register access
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Port selection
  input wire logic [1:0] read_port_i,
  input wire logic [NUM_PORTS-1:0] write_port_en_i,
  // Link events per port
  input wire logic [NUM_PORTS-1:0] seq_err_i,
  input wire logic [NUM_PORTS-1:0] crc_err_i,
  input wire logic [NUM_PORTS-1:0] lock_err_i,
  input wire logic [NUM_PORTS-1:0] enc_crc_err_i,
  input wire logic [NUM_PORTS-1:0] wdt_expire_i,
  input wire logic [NUM_PORTS-1:0] ctrl_wait_i,
  input wire logic [NUM_PORTS-1:0] tgt_wait_i,
  input wire logic [NUM_PORTS-1:0] resp_mismatch_i,
  input wire logic [NUM_PORTS-1:0] port_seq_err_i,
  // Transaction abort per port
  output logic [NUM_PORTS-1:0] abort_o
);

  logic [NUM_PORTS-1:0] cap_reg;
  logic [NUM_PORTS-1:0] cap_next;
  logic [NUM_PORTS-1:0] enh_reg;
  logic [NUM_PORTS-1:0] enh_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [NUM_PORTS-1:0] clear_vec;
  logic [5:0] flags [NUM_PORTS];
  logic [5:0] sel_flags;

  // Flags of the port that a read reaches
  assign sel_flags = flags[read_port_i];

  // Register writes, broadcast to every enabled port
  always_comb
  begin
    cap_next = cap_reg;
    enh_next = enh_reg;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      if (reg_wr_i && write_port_en_i[p])
      begin
        if (reg_addr_i == ccs_pkg::LINK_CAP_ADDR)
        begin
          cap_next[p] = reg_wdata_i[ccs_pkg::ENC_CRC_CAP_BIT];
        end
        if (reg_addr_i == ccs_pkg::ERR_CTL_ADDR)
        begin
          enh_next[p] = reg_wdata_i[ccs_pkg::ENH_EN_BIT];
        end
      end
    end
  end

  // Reads: data registered, clear strobe to selected port
  always_comb
  begin
    clear_vec = '0;
    rdata_next = 8'h00;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        ccs_pkg::ERR_CTL_ADDR:
        begin
          rdata_next[ccs_pkg::ENH_EN_BIT] = enh_reg[read_port_i];
        end
        ccs_pkg::ERR_FLAGS_ADDR:
        begin
          rdata_next[5:0] = flags[read_port_i];
          clear_vec[read_port_i] = 1'b1;
        end
        ccs_pkg::LINK_CAP_ADDR:
        begin
          rdata_next[ccs_pkg::ENC_CRC_CAP_BIT] = cap_reg[read_port_i];
        end
        default:
        begin
          rdata_next = 8'h00;
        end
      endcase
    end
    else
    begin
      rdata_next = rdata_reg;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cap_reg <= {NUM_PORTS{ccs_pkg::ENC_CRC_CAP_RST}};
      enh_reg <= {NUM_PORTS{ccs_pkg::ENH_EN_RST}};
      rdata_reg <= 8'h00;
    end
    else
    begin
      cap_reg <= cap_next;
      enh_reg <= enh_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;

  for (genvar g = 0; g < NUM_PORTS; g++)
  begin : g_port
    port_error_flags u_flags
    (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .enh_en_i(enh_reg[g]),
      .crc_cap_i(cap_reg[g]),
      .seq_err_i(seq_err_i[g]),
      .crc_err_i(crc_err_i[g]),
      .lock_err_i(lock_err_i[g]),
      .enc_crc_err_i(enc_crc_err_i[g]),
      .wdt_expire_i(wdt_expire_i[g]),
      .ctrl_wait_i(ctrl_wait_i[g]),
      .tgt_wait_i(tgt_wait_i[g]),
      .resp_mismatch_i(resp_mismatch_i[g]),
      .port_seq_err_i(port_seq_err_i[g]),
      .clear_i(clear_vec[g]),
      .flags_o(flags[g]),
      .abort_o(abort_o[g])
    );
  end

  property p_read_preclear;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    reg_rd_i && reg_addr_i == ccs_pkg::ERR_FLAGS_ADDR
      |=> reg_rdata_o == {2'b00, $past(sel_flags)};
  endproperty
  a_read_preclear: assert property (p_read_preclear)
    else $error("status read did not return pre-clear flags");

  property p_cap_read;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    reg_rd_i && reg_addr_i == ccs_pkg::LINK_CAP_ADDR
      |=> reg_rdata_o[7:5] == 3'b000 && reg_rdata_o[3:0] == 4'h0;
  endproperty
  a_cap_read: assert property (p_cap_read)
    else $error("reserved capability bits not zero");

  property p_port_write;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    reg_wr_i && reg_addr_i == ccs_pkg::LINK_CAP_ADDR && !write_port_en_i[1]
      |=> cap_reg[1] == $past(cap_reg[1]);
  endproperty
  a_port_write: assert property (p_port_write)
    else $error("write reached a port not enabled");

  property p_ctl_read;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    reg_rd_i && reg_addr_i == ccs_pkg::ERR_CTL_ADDR
      |=> reg_rdata_o[7:6] == 2'b00 && reg_rdata_o[4:0] == 5'h00;
  endproperty
  a_ctl_read: assert property (p_ctl_read)
    else $error("reserved control bits not zero");

  property p_flags_read;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    reg_rd_i && reg_addr_i == ccs_pkg::ERR_FLAGS_ADDR
      |=> reg_rdata_o[7:6] == 2'b00;
  endproperty
  a_flags_read: assert property (p_flags_read)
    else $error("reserved status bits not zero");

  property p_unmapped_read;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    reg_rd_i && reg_addr_i != ccs_pkg::ERR_CTL_ADDR
      && reg_addr_i != ccs_pkg::ERR_FLAGS_ADDR
      && reg_addr_i != ccs_pkg::LINK_CAP_ADDR |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read returned nonzero data");

  property p_rdata_hold;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");

  property p_clear_one;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    reg_rd_i && reg_addr_i == ccs_pkg::ERR_FLAGS_ADDR
      |-> $onehot(clear_vec);
  endproperty
  a_clear_one: assert property (p_clear_one)
    else $error("status read did not clear exactly one port");

  property p_cap_write;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    reg_wr_i && reg_addr_i == ccs_pkg::LINK_CAP_ADDR && write_port_en_i[0]
      |=> cap_reg[0] == $past(reg_wdata_i[ccs_pkg::ENC_CRC_CAP_BIT]);
  endproperty
  a_cap_write: assert property (p_cap_write)
    else $error("capability write not taken");

  property p_enh_write;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    reg_wr_i && reg_addr_i == ccs_pkg::ERR_CTL_ADDR && write_port_en_i[0]
      |=> enh_reg[0] == $past(reg_wdata_i[ccs_pkg::ENH_EN_BIT]);
  endproperty
  a_enh_write: assert property (p_enh_write)
    else $error("enhanced checking enable write not taken");

  property p_abort_off;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    !enh_reg[0] |=> !abort_o[0];
  endproperty
  a_abort_off: assert property (p_abort_off)
    else $error("abort raised with enhanced checking off");

endmodule : control_channel_error_status

/* File: tb/serializer_model.sv */
`timescale 1ns/1ns
module serializer_model
(
  // Stimulus from the bench
  input wire logic [35:0] hold_i,
  input wire logic [35:0] pulse_i,
  // Target side write data and echo corruption
  input wire logic [7:0] sent_i,
  input wire logic corrupt_i,
  // Link events, four bits per kind
  output logic [35:0] ev_o
);
  logic [7:0] echo;
  logic bad;
  // Echo of written data, damaged on command
  assign echo = corrupt_i ? ~sent_i : sent_i;
  assign bad = echo != sent_i;
  always_comb
  begin
    ev_o = hold_i | pulse_i;
    ev_o[31:28] = pulse_i[31:28] & {4{bad}};
  end
endmodule : serializer_model

/* File: tb/control_channel_error_status_tb_top.sv */
`timescale 1ns/1ns
module control_channel_error_status_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd_s = 1'b0;
  logic [1:0] rport = 2'h0;
  logic [3:0] wen = 4'hF;
  logic [35:0] hold = '0;
  logic [35:0] pulse = '0;
  logic corrupt = 1'b0;
  logic ab;
  wire [35:0] ev;
  logic [7:0] rdata;
  logic [3:0] abort;
  int fails = 0;
  int checks_done = 0;
  int wk[9] = '{-1, 5, 5, 5, 5, 6, 6, 6, 6};
  int pk[9] = '{0, 0, 1, 2, 4, 1, 4, 7, 3};
  logic [7:0] fx[9] = '{8'h20, 8'h30, 8'h10, 8'h10, 8'h08, 8'h04, 8'h02,
    8'h01, 8'h04};
  logic [8:0] ax = 9'h12E;

  always #50 clk = ~clk;

  serializer_model partner
  (
    .hold_i(hold),
    .pulse_i(pulse),
    .sent_i(8'h5A),
    .corrupt_i(corrupt),
    .ev_o(ev)
  );

  control_channel_error_status #(.NUM_PORTS(4)) DUT
  (
    .sys_clk_i(clk),
    .nrst_i(nrst),
    .reg_addr_i(addr),
    .reg_wdata_i(wdata),
    .reg_wr_i(wr),
    .reg_rd_i(rd_s),
    .reg_rdata_o(rdata),
    .read_port_i(rport),
    .write_port_en_i(wen),
    .seq_err_i(ev[3:0]),
    .crc_err_i(ev[7:4]),
    .lock_err_i(ev[11:8]),
    .enc_crc_err_i(ev[15:12]),
    .wdt_expire_i(ev[19:16]),
    .ctrl_wait_i(ev[23:20]),
    .tgt_wait_i(ev[27:24]),
    .resp_mismatch_i(ev[31:28]),
    .port_seq_err_i(ev[35:32]),
    .abort_o(abort)
  );

  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg

  task automatic rd(input logic [7:0] a, input logic [1:0] p,
    input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rport = p;
    rd_s = 1'b1;
    @(negedge clk);
    rd_s = 1'b0;
    check("reg_rdata_o", rdata, e);
  endtask : rd

  // One link event on port p, optionally with a wait side held
  task automatic fire(input int p, input int w, input int k);
    @(negedge clk);
    if (w >= 0)
      hold[w*4+p] = 1'b1;
    pulse[k*4+p] = 1'b1;
    @(negedge clk);
    ab = abort[p];
    pulse = '0;
    hold[27:20] = '0;
  endtask : fire

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict();
  end

  initial
  begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    rd(8'h46, 2'h0, 8'h20);
    rd(8'h47, 2'h0, 8'h00);
    rd(8'h4A, 2'h0, 8'h00);
    wr_reg(8'h47, 8'hFF);
    rd(8'h47, 2'h0, 8'h00);
    wr_reg(8'h4A, 8'hFF);
    wr_reg(8'hBA, 8'h00);
    rd(8'hBA, 2'h0, 8'h00);
    rd(8'h4A, 2'h3, 8'h10);
    $display("test reset and access done");
    corrupt = 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      fire(i % 4, wk[i], pk[i]);
      check("abort_o", {7'h00, ab}, {7'h00, ax[i]});
      rd(8'h47, 2'((i + 1) % 4), 8'h00);
      rd(8'h47, 2'(i % 4), fx[i]);
      rd(8'h47, 2'(i % 4), 8'h00);
    end
    corrupt = 1'b0;
    fire(1, 6, 7);
    rd(8'h47, 2'h1, 8'h00);
    $display("test flag table done");
    wen = 4'h1;
    wr_reg(8'h4A, 8'h00);
    wen = 4'hF;
    rd(8'h4A, 2'h1, 8'h10);
    rd(8'h4A, 2'h0, 8'h00);
    fire(0, 6, 3);
    rd(8'h47, 2'h0, 8'h00);
    @(negedge clk);
    pulse[0] = 1'b1;
    addr = 8'h47;
    rport = 2'h0;
    rd_s = 1'b1;
    @(negedge clk);
    pulse = '0;
    rd_s = 1'b0;
    check("reg_rdata_o", rdata, 8'h00);
    rd(8'h47, 2'h0, 8'h20);
    $display("test capability and read race done");
    wr_reg(8'h46, 8'h00);
    rd(8'h46, 2'h2, 8'h00);
    fire(0, 5, 2);
    check("abort_o", {7'h00, ab}, 8'h00);
    rd(8'h47, 2'h0, 8'h00);
    fire(2, 6, 4);
    rd(8'h47, 2'h2, 8'h02);
    hold[32] = 1'b1;
    @(negedge clk);
    rd(8'h47, 2'h0, 8'h20);
    rd(8'h47, 2'h0, 8'h20);
    hold[32] = 1'b0;
    repeat (2) @(negedge clk);
    rd(8'h47, 2'h0, 8'h00);
    rd(8'h50, 2'h0, 8'h00);
    $display("test enhanced off done");
    print_verdict();
  end
endmodule : control_channel_error_status_tb_top
